// [src/cfgat_top.sv]
// Configuration space decode and register access attribute engine
// Function
// - Every internal device answers as sitting on configuration bus zero.
// - The host bridge is device zero with functions zero, one and three.
// - The graphics controller answers as device two on bus zero.
// - Read-only registers return their value and ignore every write.
// - Read/write registers store and return the full written value.
// - Writing one clears a write_one_to_clear bit, writing zero keeps it.
// - A write_once bit takes one write after power-up, then is read-only.
// - Lockable bits are writable until their lock bit is set.
// - Accesses to reserved locations of any width complete normally.
// - Reserved locations read as zero and writes to them change nothing.
// - Reset loads every register default (write_once only on power-up reset); control of function zero comes from straps.
// - Internal cycles stay inside; disabled devices go out as type 0.
`default_nettype none
module cfgat_top (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  rst_por,
    input  wire logic                  cfg_req,
    input  wire logic                  cfg_write,
    input  wire logic [7:0]            cfg_bus,
    input  wire logic [4:0]            cfg_dev,
    input  wire logic [2:0]            cfg_func,
    input  wire logic [5:0]            cfg_reg,
    input  wire logic [3:0]            cfg_be,
    input  wire logic [31:0]           cfg_wdata,
    output logic                       cfg_ready,
    output logic                       cfg_ack,
    output logic [31:0]                cfg_rdata,
    output logic                       fwd_valid,
    output logic                       fwd_type1,
    output logic [21:0]                fwd_addr,
    output logic                       fwd_write,
    output logic [3:0]                 fwd_be,
    output logic [31:0]                fwd_wdata,
    input  wire logic                  gfx_enable,
    input  wire logic [3:0][15:0]      status_set,
    input  wire logic [31:0]           strap_ctrl
);
    cfgat_pkg::cfgat_state_type state, next_state;
    cfgat_pkg::cfgat_fn_type    p_sel, next_p_sel, in_sel;
    logic        p_write, next_p_write, p_absent, next_p_absent;
    logic [5:0]  p_reg, next_p_reg;
    logic [3:0]  p_be, next_p_be;
    logic [31:0] p_wdata, next_p_wdata, next_rdata, next_fwd_wdata;
    logic        next_ack, next_fwd_valid, next_fwd_type1, next_fwd_write;
    logic [21:0] next_fwd_addr;
    logic [3:0]  next_fwd_be;
    logic [3:0][15:0] status, next_status;
    logic [3:0][31:0] ctrl, next_ctrl, once, next_once;
    logic [3:0][31:0] once_done, next_once_done, lockr, next_lockr;
    logic [31:0][3:0] scr_ok, next_scr_ok;
    logic [31:0] strap_s1, strap_s2, strap_s3, strap_q, next_strap_q;
    logic [31:0] m, wm, om, lm, scr_mask;
    logic        bus0, host_hit, gfx_hit, internal, in_absent, take, wr_now;

    cfgat_mem_if mem ();

    cfgat_scratch_mem u_mem (
        .clk_sys (clk_sys),
        .mem     (mem)
    );

    // Straps are caught through a three stage chain and held when stable;
    // reset loads the next value so four reset edges are enough
    assign next_strap_q = (strap_s2 == strap_s3) ? strap_s3 : strap_q;

    always_ff @(posedge clk_sys) begin
        strap_s1 <= strap_ctrl;
        strap_s2 <= strap_s1;
        strap_s3 <= strap_s2;
        strap_q  <= next_strap_q;
    end

    assign bus0      = (cfg_bus == cfgat_pkg::BUS_ZERO);
    assign host_hit  = bus0 && (cfg_dev == cfgat_pkg::DEV_HOST);
    assign gfx_hit   = bus0 && (cfg_dev == cfgat_pkg::DEV_GFX)
                       && gfx_enable;
    assign internal  = host_hit || gfx_hit;
    assign take      = cfg_req && (state == cfgat_pkg::ST_IDLE);
    assign cfg_ready = (state == cfgat_pkg::ST_IDLE);
    assign wr_now    = (state == cfgat_pkg::ST_ACCESS) && p_write
                       && !p_absent;

    always_comb begin
        in_sel    = cfgat_pkg::SEL_GFX;
        in_absent = (cfg_func != cfgat_pkg::FN_GFX);
        if (host_hit) begin
            in_absent = 1'b0;
            case (cfg_func)
                cfgat_pkg::FN_LEGACY: in_sel = cfgat_pkg::SEL_HOST_F0;
                cfgat_pkg::FN_MEMIF:  in_sel = cfgat_pkg::SEL_HOST_F1;
                cfgat_pkg::FN_VENDOR: in_sel = cfgat_pkg::SEL_HOST_F3;
                default:              in_absent = 1'b1;
            endcase
        end
    end

    // Write port uses the held access, read port looks ahead at the request
    assign mem.addr  = (state == cfgat_pkg::ST_ACCESS) ? {p_sel, p_reg[2:0]}
                                                       : {in_sel, cfg_reg[2:0]};
    assign mem.we    = wr_now && cfgat_pkg::is_scratch(p_reg);
    assign mem.be    = p_be;
    assign mem.wdata = p_wdata;
    assign scr_mask  = cfgat_pkg::be_mask(scr_ok[{p_sel, p_reg[2:0]}]);

    always_comb begin
        next_state     = state;
        next_p_sel     = p_sel;
        next_p_write   = p_write;
        next_p_absent  = p_absent;
        next_p_reg     = p_reg;
        next_p_be      = p_be;
        next_p_wdata   = p_wdata;
        next_ack       = 1'b0;
        next_rdata     = cfg_rdata;
        next_fwd_valid = 1'b0;
        next_fwd_type1 = fwd_type1;
        next_fwd_addr  = fwd_addr;
        next_fwd_write = fwd_write;
        next_fwd_be    = fwd_be;
        next_fwd_wdata = fwd_wdata;
        unique case (state)
            cfgat_pkg::ST_IDLE: begin
                if (take && internal) begin
                    next_state    = cfgat_pkg::ST_ACCESS;
                    next_p_sel    = in_sel;
                    next_p_write  = cfg_write;
                    next_p_absent = in_absent;
                    next_p_reg    = cfg_reg;
                    next_p_be     = cfg_be;
                    next_p_wdata  = cfg_wdata;
                end else if (take) begin
                    next_fwd_valid = 1'b1;
                    next_fwd_type1 = !bus0;
                    next_fwd_addr  = {cfg_bus, cfg_dev, cfg_func, cfg_reg};
                    next_fwd_write = cfg_write;
                    next_fwd_be    = cfg_be;
                    next_fwd_wdata = cfg_wdata;
                end
            end
            cfgat_pkg::ST_ACCESS: begin
                next_state = cfgat_pkg::ST_IDLE;
                next_ack   = 1'b1;
                if (p_write) begin
                    next_rdata = cfgat_pkg::ZERO_WORD;
                end else if (p_absent) begin
                    next_rdata = cfgat_pkg::ALL_ONES;
                end else begin
                    case (p_reg)
                        cfgat_pkg::REG_IDENT:
                            next_rdata = cfgat_pkg::IDENT_VAL;
                        cfgat_pkg::REG_STATUS:
                            next_rdata = {16'h0000, status[p_sel]};
                        cfgat_pkg::REG_CTRL:
                            next_rdata = ctrl[p_sel];
                        cfgat_pkg::REG_ONCE:
                            next_rdata = once[p_sel];
                        cfgat_pkg::REG_LOCK:
                            next_rdata = lockr[p_sel];
                        default:
                            next_rdata = cfgat_pkg::is_scratch(p_reg)
                                ? (mem.rdata & scr_mask)
                                : cfgat_pkg::ZERO_WORD;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst || rst_por) begin
            state     <= cfgat_pkg::ST_IDLE;
            p_sel     <= cfgat_pkg::SEL_HOST_F0;
            p_write   <= 1'b0;
            p_absent  <= 1'b0;
            p_reg     <= cfgat_pkg::REG_IDENT;
            p_be      <= 4'h0;
            p_wdata   <= cfgat_pkg::ZERO_WORD;
            cfg_ack   <= 1'b0;
            cfg_rdata <= cfgat_pkg::ZERO_WORD;
            fwd_valid <= 1'b0;
            fwd_type1 <= 1'b0;
            fwd_addr  <= 22'h00_0000;
            fwd_write <= 1'b0;
            fwd_be    <= 4'h0;
            fwd_wdata <= cfgat_pkg::ZERO_WORD;
        end else begin
            state     <= next_state;
            p_sel     <= next_p_sel;
            p_write   <= next_p_write;
            p_absent  <= next_p_absent;
            p_reg     <= next_p_reg;
            p_be      <= next_p_be;
            p_wdata   <= next_p_wdata;
            cfg_ack   <= next_ack;
            cfg_rdata <= next_rdata;
            fwd_valid <= next_fwd_valid;
            fwd_type1 <= next_fwd_type1;
            fwd_addr  <= next_fwd_addr;
            fwd_write <= next_fwd_write;
            fwd_be    <= next_fwd_be;
            fwd_wdata <= next_fwd_wdata;
        end
    end

    always_comb begin
        m              = cfgat_pkg::be_mask(p_be);
        wm             = p_wdata & m;
        om             = m & ~once_done[p_sel];
        lm             = m & cfgat_pkg::LOCKABLE
                         & {32{~lockr[p_sel][31]}};
        // Hardware set is applied after any clear so a coincident event wins
        next_status    = status;
        next_ctrl      = ctrl;
        next_once      = once;
        next_once_done = once_done;
        next_lockr     = lockr;
        next_scr_ok    = scr_ok;
        if (wr_now) begin
            case (p_reg)
                cfgat_pkg::REG_STATUS:
                    next_status[p_sel] = status[p_sel] & ~wm[15:0];
                cfgat_pkg::REG_CTRL:
                    next_ctrl[p_sel] = (ctrl[p_sel] & ~m) | wm;
                cfgat_pkg::REG_ONCE: begin
                    next_once[p_sel] = (once[p_sel] & ~om)
                                       | (p_wdata & om);
                    next_once_done[p_sel] = once_done[p_sel] | m;
                end
                cfgat_pkg::REG_LOCK:
                    next_lockr[p_sel] = (lockr[p_sel] & ~lm)
                        | (p_wdata & lm)
                        | (wm & cfgat_pkg::LOCK_SET);
                default:
                    if (cfgat_pkg::is_scratch(p_reg)) begin
                        next_scr_ok[{p_sel, p_reg[2:0]}] =
                            scr_ok[{p_sel, p_reg[2:0]}] | p_be;
                    end
            endcase
        end
        next_status = next_status | status_set;
    end

    always_ff @(posedge clk_sys) begin
        if (rst_por) begin
            once      <= {cfgat_pkg::NFN{cfgat_pkg::ONCE_RST}};
            once_done <= '0;
        end else begin
            once      <= next_once;
            once_done <= next_once_done;
        end
        if (rst || rst_por) begin
            status    <= {cfgat_pkg::NFN{cfgat_pkg::STATUS_RST}};
            ctrl      <= {cfgat_pkg::NFN{cfgat_pkg::CTRL_RST}};
            ctrl[0]   <= next_strap_q;
            lockr     <= {cfgat_pkg::NFN{cfgat_pkg::LOCK_RST}};
            scr_ok    <= '0;
        end else begin
            status    <= next_status;
            ctrl      <= next_ctrl;
            lockr     <= next_lockr;
            scr_ok    <= next_scr_ok;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || rst_por);

    sequence s_take_int;
        cfg_req && cfg_ready && internal;
    endsequence
    sequence s_answer;
        ##2 cfg_ack;
    endsequence

    ack_latency_a: assert property (s_take_int |-> s_answer)
        else $error("internal access not answered two cycles later");
    fwd_route_a: assert property (cfg_req && cfg_ready && !internal
        |=> fwd_valid && !cfg_ack ##1 !cfg_ack)
        else $error("external access not forwarded");
    fwd_type_a: assert property (fwd_valid |-> fwd_type1
        == (fwd_addr[21:14] != cfgat_pkg::BUS_ZERO))
        else $error("forward cycle type wrong");
    ident_ro_a: assert property (cfg_ack && !p_write && !p_absent
        && p_reg == cfgat_pkg::REG_IDENT
        |-> cfg_rdata == cfgat_pkg::IDENT_VAL)
        else $error("read-only value disturbed");
    rsvd_zero_a: assert property (cfg_ack && !p_write && !p_absent
        && cfgat_pkg::is_reserved(p_reg) |-> cfg_rdata == '0)
        else $error("reserved location read non-zero");
    w1c_clear_a: assert property (wr_now && p_reg == cfgat_pkg::REG_STATUS
        && p_be[0] && p_wdata[0] && !status_set[p_sel][0]
        |=> status[p_sel][0] == 1'b0)
        else $error("write one did not clear status bit");
    ctrl_store_a: assert property (wr_now && p_be == 4'hf
        && p_reg == cfgat_pkg::REG_CTRL
        |=> ctrl[p_sel] == $past(p_wdata))
        else $error("control word not stored");
    once_hold_a: assert property (wr_now && p_reg == cfgat_pkg::REG_ONCE
        && once_done[p_sel] == cfgat_pkg::ALL_ONES
        |=> $stable(once[p_sel]))
        else $error("write-once bit changed twice");
    lock_hold_a: assert property (wr_now && p_reg == cfgat_pkg::REG_LOCK
        && lockr[p_sel][31] |=> $stable(lockr[p_sel]))
        else $error("locked bits changed");
endmodule
`default_nettype wire

// [src/cfgat_pkg.sv]
// Constants, types and helpers shared by the configuration attribute block
`default_nettype none
package cfgat_pkg;
    localparam logic [7:0]  BUS_ZERO     = 8'h00;
    localparam logic [4:0]  DEV_HOST     = 5'h00;
    localparam logic [4:0]  DEV_GFX      = 5'h02;
    localparam logic [2:0]  FN_LEGACY    = 3'h0;
    localparam logic [2:0]  FN_MEMIF     = 3'h1;
    localparam logic [2:0]  FN_VENDOR    = 3'h3;
    localparam logic [2:0]  FN_GFX       = 3'h0;
    localparam logic [5:0]  REG_IDENT    = 6'h00;
    localparam logic [5:0]  REG_STATUS   = 6'h01;
    localparam logic [5:0]  REG_CTRL     = 6'h02;
    localparam logic [5:0]  REG_ONCE     = 6'h03;
    localparam logic [5:0]  REG_LOCK     = 6'h04;
    localparam logic [5:0]  REG_SCR_LO   = 6'h08;
    localparam logic [5:0]  REG_SCR_HI   = 6'h0f;
    localparam int          SCR_AW       = 5;
    localparam int          NFN          = 4;
    // Identity value is arbitrary
    localparam logic [31:0] IDENT_VAL    = 32'h0001_5a5a;
    localparam logic [15:0] STATUS_RST   = 16'h0000;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] ONCE_RST     = 32'h0000_0000;
    localparam logic [31:0] LOCK_RST     = 32'h0000_0000;
    localparam logic [31:0] LOCK_SET     = 32'h8000_0000;
    localparam logic [31:0] LOCKABLE     = 32'h7fff_ffff;
    localparam logic [31:0] ALL_ONES     = 32'hffff_ffff;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEL_HOST_F0 = 2'b00,
        SEL_HOST_F1 = 2'b01,
        SEL_HOST_F3 = 2'b10,
        SEL_GFX     = 2'b11
    } cfgat_fn_type;

    typedef enum logic {
        ST_IDLE   = 1'b0,
        ST_ACCESS = 1'b1
    } cfgat_state_type;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic is_scratch(input logic [5:0] idx);
        is_scratch = (idx >= REG_SCR_LO) && (idx <= REG_SCR_HI);
    endfunction

    function automatic logic is_reserved(input logic [5:0] idx);
        is_reserved = !is_scratch(idx) && (idx > REG_LOCK);
    endfunction
endpackage
`default_nettype wire

// [src/cfgat_mem_if.sv]
// Port group between the access engine and its scratch word store
`default_nettype none
interface cfgat_mem_if;
    logic [cfgat_pkg::SCR_AW-1:0] addr;
    logic                         we;
    logic [3:0]                   be;
    logic [31:0]                  wdata;
    logic [31:0]                  rdata;
    modport owner (output addr, output we, output be, output wdata,
                   input rdata);
    modport store (input addr, input we, input be, input wdata,
                   output rdata);
endinterface
`default_nettype wire

// [src/cfgat_scratch_mem.sv]
// Byte-writable scratch word store with registered read data
`default_nettype none
module cfgat_scratch_mem (
    input wire logic clk_sys,
    cfgat_mem_if.store mem
);
    logic [31:0] words [2**cfgat_pkg::SCR_AW];

    always_ff @(posedge clk_sys) begin
        if (mem.we) begin
            for (int b = 0; b < 4; b++) begin
                if (mem.be[b]) begin
                    words[mem.addr][8*b +: 8] <= mem.wdata[8*b +: 8];
                end
            end
        end
        mem.rdata <= words[mem.addr];
    end
endmodule
`default_nettype wire

// [dv/cfgat_fwd_sink.sv]
// Hub link sink that records configuration cycles forwarded by the block
`default_nettype none
module cfgat_fwd_sink (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        fwd_valid,
    input  wire logic        fwd_type1,
    input  wire logic [21:0] fwd_addr,
    output logic [7:0]       n_fwd,
    output logic             last_type1,
    output logic [21:0]      last_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Takes every cycle at once: the link side here has no back pressure
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            n_fwd <= 8'h00;
            last_type1 <= 1'b0;
            last_addr <= 22'h000000;
        end else if (fwd_valid) begin
            n_fwd <= n_fwd + 8'h01;
            last_type1 <= fwd_type1;
            last_addr <= fwd_addr;
        end
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the configuration attribute engine
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin \
    fail_count++; $display("Error %s expected %h seen %h", nm, ex, sn); \
    end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] STRAP = 32'h00c3_0a50;
    logic             clk_sys = 1'b0;
    logic             rst = 1'b1;
    logic             rst_por = 1'b1;
    logic             cfg_req = 1'b0;
    logic             cfg_write = 1'b0;
    logic [7:0]       cfg_bus = 8'h00;
    logic [4:0]       cfg_dev = 5'h00;
    logic [2:0]       cfg_func = 3'h0;
    logic [5:0]       cfg_reg = 6'h00;
    logic [3:0]       cfg_be = 4'h0;
    logic [31:0]      cfg_wdata = 32'h0;
    logic             cfg_ready, cfg_ack, fwd_valid, fwd_type1, fwd_write;
    logic [31:0]      cfg_rdata, fwd_wdata;
    logic [21:0]      fwd_addr, last_addr;
    logic [3:0]       fwd_be;
    logic             gfx_enable = 1'b1;
    logic [3:0][15:0] status_set = '0;
    logic [7:0]       n_fwd;
    logic             last_type1;
    logic [31:0]      rdv;
    logic [1:0]       knd;
    int               fail_count = 0;
    int               n_compared = 0;
    always #2.5 clk_sys = ~clk_sys;
    cfgat_top u_dut (.clk_sys(clk_sys), .rst(rst), .rst_por(rst_por),
        .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_bus(cfg_bus),
        .cfg_dev(cfg_dev), .cfg_func(cfg_func), .cfg_reg(cfg_reg),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ready(cfg_ready),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .fwd_valid(fwd_valid),
        .fwd_type1(fwd_type1), .fwd_addr(fwd_addr), .fwd_write(fwd_write),
        .fwd_be(fwd_be), .fwd_wdata(fwd_wdata), .gfx_enable(gfx_enable),
        .status_set(status_set), .strap_ctrl(STRAP));
    cfgat_fwd_sink u_sink (.clk_sys(clk_sys), .rst(rst_por),
        .fwd_valid(fwd_valid), .fwd_type1(fwd_type1), .fwd_addr(fwd_addr),
        .n_fwd(n_fwd), .last_type1(last_type1), .last_addr(last_addr));
    // Kind 1 is an internal answer, kind 2 a forwarded cycle
    task automatic acc(input logic wr, input logic [7:0] b,
        input logic [4:0] d, input logic [2:0] f, input logic [5:0] r,
        input logic [3:0] be, input logic [31:0] wd);
        int i;
        @(posedge clk_sys);
        cfg_req <= 1'b1;
        cfg_write <= wr;
        cfg_bus <= b;
        cfg_dev <= d;
        cfg_func <= f;
        cfg_reg <= r;
        cfg_be <= be;
        cfg_wdata <= wd;
        @(posedge clk_sys);
        cfg_req <= 1'b0;
        knd = 2'd0;
        rdv = 32'h0;
        for (i = 0; i < 4 && knd == 2'd0; i++) begin
            #1;
            if (cfg_ack === 1'b1) begin
                knd = 2'd1;
                rdv = cfg_rdata;
            end else if (fwd_valid === 1'b1) begin
                knd = 2'd2;
            end
            @(posedge clk_sys);
        end
        // Lets the sink take a forwarded cycle before anyone looks at it
        @(posedge clk_sys);
    endtask
    task automatic w0(input logic [2:0] f, input logic [5:0] r,
        input logic [3:0] be, input logic [31:0] wd);
        acc(1'b1, 8'h00, 5'h00, f, r, be, wd);
    endtask
    task automatic r0(input logic [2:0] f, input logic [5:0] r);
        acc(1'b0, 8'h00, 5'h00, f, r, 4'hf, 32'h0);
    endtask
    task automatic do_reset(input logic por);
        @(posedge clk_sys);
        if (por) rst_por <= 1'b1;
        else rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rst_por <= 1'b0;
    endtask
    task automatic t_defaults;
        r0(3'h0, cfgat_pkg::REG_CTRL);
        `CHK("ctrl strap", STRAP, rdv)
        r0(3'h1, cfgat_pkg::REG_CTRL);
        `CHK("ctrl fn1", cfgat_pkg::CTRL_RST, rdv)
        r0(3'h0, cfgat_pkg::REG_STATUS);
        `CHK("status rst", 32'h0, rdv)
    endtask
    task automatic t_ro_rw;
        w0(3'h0, cfgat_pkg::REG_IDENT, 4'hf, 32'h1234_0000);
        r0(3'h0, cfgat_pkg::REG_IDENT);
        `CHK("ident", cfgat_pkg::IDENT_VAL, rdv)
        w0(3'h1, cfgat_pkg::REG_CTRL, 4'hf, 32'hdead_beef);
        w0(3'h1, cfgat_pkg::REG_CTRL, 4'h6, 32'h0011_2200);
        r0(3'h1, cfgat_pkg::REG_CTRL);
        `CHK("ctrl rw", 32'hde11_22ef, rdv)
        w0(3'h0, cfgat_pkg::REG_SCR_LO, 4'h5, 32'h1122_3344);
        r0(3'h0, cfgat_pkg::REG_SCR_LO);
        `CHK("scratch", 32'h0022_0044, rdv)
        w0(3'h0, cfgat_pkg::REG_SCR_LO, 4'hf, rdv | 32'h0000_5500);
        r0(3'h0, cfgat_pkg::REG_SCR_LO);
        `CHK("scratch merge", 32'h0022_5544, rdv)
    endtask
    task automatic t_w1c;
        @(posedge clk_sys);
        status_set[0] <= 16'h0029;
        @(posedge clk_sys);
        status_set[0] <= 16'h0000;
        w0(3'h0, cfgat_pkg::REG_STATUS, 4'h1, 32'h0000_0009);
        r0(3'h0, cfgat_pkg::REG_STATUS);
        `CHK("status clr", 32'h0000_0020, rdv)
        w0(3'h0, cfgat_pkg::REG_STATUS, 4'hf, 32'h0000_0000);
        r0(3'h0, cfgat_pkg::REG_STATUS);
        `CHK("status keep", 32'h0000_0020, rdv)
    endtask
    task automatic t_once;
        w0(3'h0, cfgat_pkg::REG_ONCE, 4'h1, 32'h0000_00a5);
        w0(3'h0, cfgat_pkg::REG_ONCE, 4'hf, 32'h7e7e_3c5a);
        r0(3'h0, cfgat_pkg::REG_ONCE);
        `CHK("once", 32'h7e7e_3ca5, rdv)
        do_reset(1'b0);
        r0(3'h0, cfgat_pkg::REG_ONCE);
        `CHK("once warm", 32'h7e7e_3ca5, rdv)
        w0(3'h0, cfgat_pkg::REG_ONCE, 4'h1, 32'h0000_0011);
        r0(3'h0, cfgat_pkg::REG_ONCE);
        `CHK("once shut", 32'h7e7e_3ca5, rdv)
        do_reset(1'b1);
        r0(3'h0, cfgat_pkg::REG_ONCE);
        `CHK("once por", cfgat_pkg::ONCE_RST, rdv)
    endtask
    task automatic t_lock;
        w0(3'h1, cfgat_pkg::REG_LOCK, 4'hf, 32'h1234_5678);
        w0(3'h1, cfgat_pkg::REG_LOCK, 4'h8, 32'h8000_0000);
        w0(3'h1, cfgat_pkg::REG_LOCK, 4'hf, 32'h0000_ffff);
        r0(3'h1, cfgat_pkg::REG_LOCK);
        `CHK("locked", 32'h8034_5678, rdv)
    endtask
    task automatic t_reserved;
        logic [3:0] bes [3];
        int k;
        bes = '{4'h1, 4'h3, 4'hf};
        for (k = 0; k < 3; k++) begin
            w0(3'h0, 6'h05, bes[k], cfgat_pkg::ALL_ONES);
            `CHK("resv wr ack", 2'd1, knd)
            r0(3'h0, 6'h10);
            `CHK("resv rd", cfgat_pkg::ZERO_WORD, rdv)
        end
        r0(3'h0, 6'h05);
        `CHK("resv keep", cfgat_pkg::ZERO_WORD, rdv)
        r0(3'h0, cfgat_pkg::REG_CTRL);
        `CHK("resv side", STRAP, rdv)
    endtask
    task automatic t_route;
        r0(3'h1, cfgat_pkg::REG_IDENT);
        `CHK("fn1", cfgat_pkg::IDENT_VAL, rdv)
        r0(3'h3, cfgat_pkg::REG_IDENT);
        `CHK("fn3", cfgat_pkg::IDENT_VAL, rdv)
        r0(3'h2, cfgat_pkg::REG_IDENT);
        `CHK("fn2 absent", cfgat_pkg::ALL_ONES, rdv)
        acc(1'b0, 8'h00, 5'h02, 3'h0, cfgat_pkg::REG_IDENT, 4'hf, 32'h0);
        `CHK("gfx on", 2'd1, knd)
        gfx_enable <= 1'b0;
        acc(1'b0, 8'h00, 5'h02, 3'h0, 6'h01, 4'hf, 32'h0);
        `CHK("gfx off", 2'd2, knd)
        `CHK("type0", 1'b0, last_type1)
        `CHK("fwd addr", 22'h000401, last_addr)
        acc(1'b0, 8'h01, 5'h00, 3'h0, 6'h00, 4'hf, 32'h0);
        `CHK("type1", 1'b1, last_type1)
        `CHK("fwd count", 8'h02, n_fwd)
        gfx_enable <= 1'b1;
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rst_por <= 1'b0;
        t_defaults();
        t_ro_rw();
        t_w1c();
        t_once();
        t_lock();
        t_reserved();
        t_route();
        end_of_test();
    end
    // About 220 cycles are needed; the limit leaves a wide margin
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
